// [hw/rpx_pkg.sv]
/*
 * constants, message layout and configuration types of the remote point
 * state exchange block.
 * assumes a single 50 MHz clock and a plain register port.
 */
`default_nettype none

package rpx_pkg;
   // ======================================================
   // message format
   localparam int NUM_PAIRS = 128;
   localparam int NUM_PRE = 32;
   localparam int NUM_USER_FMT = 96;
   localparam int NUM_USER = 32;
   localparam int NUM_PTS = NUM_PRE + NUM_USER;
   localparam int ID_CHARS = 20;
   localparam int ID_W = ID_CHARS * 8;
   localparam int ID_WORDS = 5;
   localparam int HOLD_W = 8;
   localparam logic [1:0] PAIR_ON = 2'h2;
   localparam logic [1:0] PAIR_OFF = 2'h1;
   localparam logic [1:0] PAIR_NONE = 2'h0;

   // ======================================================
   // receiver and transmitter sizes
   localparam int NUM_DEV = 16;
   localparam int DEV_W = 5;
   localparam int SEL_W = 6;
   localparam int NUM_RIN = 32;
   localparam int NUM_RIN_PTS = 64;
   localparam int NUM_ROUT = 32;
   localparam int IVL_W = 6;
   localparam logic [IVL_W-1:0] IVL_MIN = 6'h01;
   localparam logic [IVL_W-1:0] IVL_MAX = 6'h3C;
   localparam logic [IVL_W-1:0] IVL_RST = 6'h3C;
   localparam logic [HOLD_W-1:0] HOLD_MULT = 8'h03;

   // ======================================================
   // timing
   localparam int SECOND_NS = 1000000000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CYC_PER_SEC = SECOND_NS / CLK_PERIOD_NS;

   // ======================================================
   // register map, word addresses
   localparam int AW = 8;
   localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [AW-1:0] ADDR_ONLINE = 8'h01;
   localparam logic [AW-1:0] ADDR_RIN_VAL = 8'h02;
   localparam logic [AW-1:0] ADDR_LID_BASE = 8'h08;
   localparam logic [2:0] ADDR_RIN_PAGE = 3'h1;
   localparam int RIN_SEL_LSB = 0;
   localparam int RIN_DEV_LSB = 8;
   localparam int RIN_DEF_BIT = 16;

   // ======================================================
   // types
   typedef struct packed {
      logic [ID_W-1:0] origin;
      logic [HOLD_W-1:0] hold_s;
      logic [NUM_PAIRS*2-1:0] pairs;
   } rpx_msg_s;

   typedef struct packed {
      logic dflt;
      logic [DEV_W-1:0] dev;
      logic [SEL_W-1:0] sel;
   } rpx_rin_cfg_s;

   typedef enum logic {RX_IDLE, RX_SEARCH} rpx_rx_e;
endpackage

`default_nettype wire

// [hw/rpx_top.sv]
/*
 * remote point state exchange: sends local point states in event messages
 * and turns received messages into supervised remote input states.
 * assumes operand inputs and message streams come from logic on sys_clk_in;
 * the register master keeps the one-cycle strobe protocol.
 */
// Behaviour
// - each message carries 128 bit pairs, one per digital point
// - first 32 pairs are predefined events, the rest user events
// - only 32 of the 96 user pairs are used
// - send after power-up, on any point change, and when the interval elapses
// - sent hold time is three times the resend interval
// - accept data only from originators matching a configured remote device
// - accepted message loads device hold timer; expiry forces default states
// - message before expiry updates device points carrying a valid pair and restarts the timer
// - per-device readable status shows offline while non-communicating
// - 32 remote input points and 32 remote output points
// - sixteen device entries, each a 20-character identity matched exactly
// - each remote input selects one of 64 sources, predefined or user
// - each input names source device 1..16 and a pair, reproduces it
// - input shows its default after startup and while source is offline
// - resend interval programmable 1..60 s, default 60 s
// - each sent point carries the state of one internal operand
`default_nettype none

module rpx_top #(
   parameter int SEC_CYCLES = rpx_pkg::CYC_PER_SEC
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic [rpx_pkg::AW-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [rpx_pkg::NUM_PRE-1:0] pre_op_in,
   input wire logic [rpx_pkg::NUM_USER-1:0] user_op_in,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   output rpx_pkg::rpx_msg_s tx_msg_out,
   input wire logic rx_valid_in,
   output logic rx_ready_out,
   input wire rpx_pkg::rpx_msg_s rx_msg_in,
   output logic [rpx_pkg::NUM_RIN-1:0] remote_in_out,
   output logic [rpx_pkg::NUM_DEV-1:0] dev_online_out
);
   localparam int SEC_W = $clog2(SEC_CYCLES);
   localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);
   localparam logic [3:0] DEV_LAST = 4'hF;

   // ======================================================
   // state
   typedef struct packed {
      logic [rpx_pkg::NUM_DEV-1:0][rpx_pkg::ID_W-1:0] dev_id;
      logic [rpx_pkg::ID_W-1:0] local_id;
      rpx_pkg::rpx_rin_cfg_s [rpx_pkg::NUM_RIN-1:0] rin_cfg;
      logic [rpx_pkg::IVL_W-1:0] ivl;
      logic [rpx_pkg::NUM_DEV-1:0][rpx_pkg::HOLD_W-1:0] hold;
      logic [rpx_pkg::NUM_DEV-1:0][rpx_pkg::NUM_RIN_PTS-1:0] pts;
      logic [rpx_pkg::NUM_DEV-1:0] online;
      rpx_pkg::rpx_msg_s [1:0] fifo;
      logic wp;
      logic rp;
      logic [1:0] cnt;
      logic rx_rdy;
      rpx_pkg::rpx_rx_e rx_st;
      logic [3:0] idx;
      logic [SEC_W-1:0] sec_cnt;
      logic [rpx_pkg::IVL_W-1:0] ivl_cnt;
      logic [rpx_pkg::NUM_PTS-1:0] ops_prev;
      logic pend;
      logic tx_vld;
      rpx_pkg::rpx_msg_s tx_msg;
      logic [31:0] rdata;
      logic [rpx_pkg::NUM_RIN-1:0] rin_val;
   } rpx_state_s;

   rpx_state_s st_ff;
   rpx_state_s nxt_st;

   // ======================================================
   // helpers
   function automatic logic [1:0] pair_enc(input logic v);
      pair_enc = v ? rpx_pkg::PAIR_ON : rpx_pkg::PAIR_OFF;
   endfunction

   function automatic logic pair_dec(input logic [1:0] p, input logic old);
      if (p == rpx_pkg::PAIR_ON) begin
         pair_dec = 1'b1;
      end else if (p == rpx_pkg::PAIR_OFF) begin
         pair_dec = 1'b0;
      end else begin
         pair_dec = old;
      end
   endfunction

   // ======================================================
   // next state
   always_comb begin
      logic tick;
      logic push;
      logic pop;
      logic [rpx_pkg::NUM_PTS-1:0] ops;
      rpx_pkg::rpx_msg_s head;
      rpx_pkg::rpx_msg_s msg;
      logic [3:0] dn;
      logic [2:0] w;
      tick = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      ops = '0;
      head = '0;
      msg = '0;
      dn = '0;
      w = '0;
      nxt_st = st_ff;

      // one second time base
      tick = (st_ff.sec_cnt == SEC_LAST);
      nxt_st.sec_cnt = tick ? '0 : st_ff.sec_cnt + 1'b1;

      for (int d = 0; d < rpx_pkg::NUM_DEV; d++) begin
         if (tick && st_ff.hold[d] != '0) begin
            nxt_st.hold[d] = st_ff.hold[d] - 1'b1;
         end
      end

      // receive path: search the entries one per cycle, so the buffer can fill
      push = rx_valid_in && st_ff.rx_rdy;
      head = st_ff.fifo[st_ff.rp];
      case (st_ff.rx_st)
         rpx_pkg::RX_IDLE: begin
            if (st_ff.cnt != 2'h0) begin
               nxt_st.rx_st = rpx_pkg::RX_SEARCH;
               nxt_st.idx = '0;
            end
         end
         rpx_pkg::RX_SEARCH: begin
            if (st_ff.dev_id[st_ff.idx] != '0 && st_ff.dev_id[st_ff.idx] == head.origin) begin
               for (int p = 0; p < rpx_pkg::NUM_RIN_PTS; p++) begin
                  nxt_st.pts[st_ff.idx][p] =
                     pair_dec(head.pairs[p*2 +: 2], st_ff.pts[st_ff.idx][p]);
               end
               nxt_st.hold[st_ff.idx] = head.hold_s;
               pop = 1'b1;
               nxt_st.rx_st = rpx_pkg::RX_IDLE;
            end else if (st_ff.idx == DEV_LAST) begin
               pop = 1'b1;
               nxt_st.rx_st = rpx_pkg::RX_IDLE;
            end else begin
               nxt_st.idx = st_ff.idx + 1'b1;
            end
         end
         default: begin
            nxt_st.rx_st = rpx_pkg::RX_IDLE;
         end
      endcase

      // two-entry buffer
      if (push) begin
         nxt_st.fifo[st_ff.wp] = rx_msg_in;
         nxt_st.wp = ~st_ff.wp;
      end
      if (pop) begin
         nxt_st.rp = ~st_ff.rp;
      end
      case ({push, pop})
         2'b10: nxt_st.cnt = st_ff.cnt + 1'b1;
         2'b01: nxt_st.cnt = st_ff.cnt - 1'b1;
         default: nxt_st.cnt = st_ff.cnt;
      endcase
      nxt_st.rx_rdy = (nxt_st.cnt != 2'h2);

      for (int d = 0; d < rpx_pkg::NUM_DEV; d++) begin
         nxt_st.online[d] = (nxt_st.hold[d] != '0);
      end

      ops = {user_op_in, pre_op_in};
      nxt_st.ops_prev = ops;
      if (ops != st_ff.ops_prev) begin
         nxt_st.pend = 1'b1;
      end
      if (tick) begin
         if (st_ff.ivl_cnt + 1'b1 >= st_ff.ivl) begin
            nxt_st.pend = 1'b1;
            nxt_st.ivl_cnt = '0;
         end else begin
            nxt_st.ivl_cnt = st_ff.ivl_cnt + 1'b1;
         end
      end
      if (st_ff.tx_vld && tx_ready_in) begin
         nxt_st.tx_vld = 1'b0;
      end
      // message is frozen while offered; a change meanwhile queues one more
      if ((!st_ff.tx_vld || tx_ready_in) && nxt_st.pend) begin
         msg.origin = st_ff.local_id;
         msg.hold_s = rpx_pkg::HOLD_MULT * {2'h0, st_ff.ivl};
         msg.pairs = '0;
         for (int p = 0; p < rpx_pkg::NUM_PTS; p++) begin
            msg.pairs[p*2 +: 2] = pair_enc(ops[p]);
         end
         nxt_st.tx_msg = msg;
         nxt_st.tx_vld = 1'b1;
         nxt_st.pend = 1'b0;
         nxt_st.ivl_cnt = '0;
      end

      // remote inputs
      for (int i = 0; i < rpx_pkg::NUM_RIN; i++) begin
         dn = st_ff.rin_cfg[i].dev[3:0] - 1'b1;
         if (st_ff.rin_cfg[i].dev != '0
             && st_ff.rin_cfg[i].dev <= rpx_pkg::DEV_W'(rpx_pkg::NUM_DEV)
             && st_ff.online[dn]) begin
            nxt_st.rin_val[i] = st_ff.pts[dn][st_ff.rin_cfg[i].sel];
         end else begin
            nxt_st.rin_val[i] = st_ff.rin_cfg[i].dflt;
         end
      end

      // register writes
      w = reg_addr_in[2:0];
      if (reg_wr_in) begin
         if (reg_addr_in == rpx_pkg::ADDR_CTRL) begin
            if (reg_wdata_in[rpx_pkg::IVL_W-1:0] >= rpx_pkg::IVL_MIN
                && reg_wdata_in[rpx_pkg::IVL_W-1:0] <= rpx_pkg::IVL_MAX
                && reg_wdata_in[31:rpx_pkg::IVL_W] == '0) begin
               nxt_st.ivl = reg_wdata_in[rpx_pkg::IVL_W-1:0];
            end
         end else if (reg_addr_in[7:3] == rpx_pkg::ADDR_LID_BASE[7:3]) begin
            if (w < 3'(rpx_pkg::ID_WORDS)) begin
               nxt_st.local_id[w*32 +: 32] = reg_wdata_in;
            end
         end else if (reg_addr_in[7:5] == rpx_pkg::ADDR_RIN_PAGE) begin
            nxt_st.rin_cfg[reg_addr_in[4:0]].sel =
               reg_wdata_in[rpx_pkg::RIN_SEL_LSB +: rpx_pkg::SEL_W];
            nxt_st.rin_cfg[reg_addr_in[4:0]].dev =
               reg_wdata_in[rpx_pkg::RIN_DEV_LSB +: rpx_pkg::DEV_W];
            nxt_st.rin_cfg[reg_addr_in[4:0]].dflt = reg_wdata_in[rpx_pkg::RIN_DEF_BIT];
         end else if (reg_addr_in[7]) begin
            if (w < 3'(rpx_pkg::ID_WORDS)) begin
               nxt_st.dev_id[reg_addr_in[6:3]][w*32 +: 32] = reg_wdata_in;
            end
         end
      end

      // register reads, answer in the next cycle only
      nxt_st.rdata = '0;
      if (reg_rd_in) begin
         if (reg_addr_in == rpx_pkg::ADDR_CTRL) begin
            nxt_st.rdata = {26'h0, st_ff.ivl};
         end else if (reg_addr_in == rpx_pkg::ADDR_ONLINE) begin
            nxt_st.rdata = {16'h0, st_ff.online};
         end else if (reg_addr_in == rpx_pkg::ADDR_RIN_VAL) begin
            nxt_st.rdata = st_ff.rin_val;
         end else if (reg_addr_in[7:3] == rpx_pkg::ADDR_LID_BASE[7:3]) begin
            if (w < 3'(rpx_pkg::ID_WORDS)) begin
               nxt_st.rdata = st_ff.local_id[w*32 +: 32];
            end
         end else if (reg_addr_in[7:5] == rpx_pkg::ADDR_RIN_PAGE) begin
            nxt_st.rdata = {15'h0, st_ff.rin_cfg[reg_addr_in[4:0]].dflt, 3'h0,
                            st_ff.rin_cfg[reg_addr_in[4:0]].dev, 2'h0,
                            st_ff.rin_cfg[reg_addr_in[4:0]].sel};
         end else if (reg_addr_in[7]) begin
            if (w < 3'(rpx_pkg::ID_WORDS)) begin
               nxt_st.rdata = st_ff.dev_id[reg_addr_in[6:3]][w*32 +: 32];
            end
         end
      end
   end

   // ======================================================
   // registers
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
         st_ff.ivl <= rpx_pkg::IVL_RST;
         st_ff.pend <= 1'b1;
         st_ff.rx_rdy <= 1'b1;
         st_ff.hold <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ======================================================
   // outputs
   assign reg_rdata_out = st_ff.rdata;
   assign tx_valid_out = st_ff.tx_vld;
   assign tx_msg_out = st_ff.tx_msg;
   assign rx_ready_out = st_ff.rx_rdy;
   assign remote_in_out = st_ff.rin_val;
   assign dev_online_out = st_ff.online;
endmodule

`default_nettype wire

// [dv/rpx_top_properties.sv]
/*
 * port checker of the point state exchange block.
 * bound into every rpx_top; sees its ports only.
 */
`default_nettype none

module rpx_top_properties #(
   parameter int SEC_CYCLES = 10
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic [rpx_pkg::AW-1:0] reg_addr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [rpx_pkg::NUM_PRE-1:0] pre_op_in,
   input wire logic [rpx_pkg::NUM_USER-1:0] user_op_in,
   input wire logic tx_valid_out,
   input wire logic tx_ready_in,
   input wire rpx_pkg::rpx_msg_s tx_msg_out,
   input wire logic rx_valid_in,
   input wire logic rx_ready_out,
   input wire logic [rpx_pkg::NUM_DEV-1:0] dev_online_out
);
   // ====================
   // helper counters
   int since_take_ff;
   int idle_ff;
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         since_take_ff <= 1000;
         idle_ff <= 0;
      end else begin
         if (rx_valid_in && rx_ready_out) since_take_ff <= 0;
         else if (since_take_ff < 1000) since_take_ff <= since_take_ff + 1;
         idle_ff <= tx_valid_out ? 0 : idle_ff + 1;
      end
   end

   // ====================
   // properties
   hold_triple_a: assert property (
      tx_valid_out |-> tx_msg_out.hold_s % 8'h03 == 8'h00
      && tx_msg_out.hold_s inside {[8'h03:8'hB4]}) else $error("bad hold time");
   unused_pairs_a: assert property (
      tx_valid_out |-> tx_msg_out.pairs[255:128] == 128'h0) else $error("unused pair set");
   first_pairs_a: assert property (
      $rose(tx_valid_out) && $stable(pre_op_in) && $stable(user_op_in) |->
      tx_msg_out.pairs[1:0] == {pre_op_in[0], !pre_op_in[0]}
      && tx_msg_out.pairs[65:64] == {user_op_in[0], !user_op_in[0]}) else $error("pair wrong");
   tx_hold_a: assert property (
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_msg_out))
      else $error("message dropped");
   change_send_a: assert property (
      $changed(pre_op_in) || $changed(user_op_in) |-> ##[0:3] tx_valid_out)
      else $error("no send on change");
   idle_send_a: assert property (
      idle_ff < 61 * SEC_CYCLES) else $error("no idle resend");
   online_read_a: assert property (
      reg_rd_in && reg_addr_in == rpx_pkg::ADDR_ONLINE |=>
      reg_rdata_out == {16'h0000, $past(dev_online_out)}) else $error("status read wrong");
   online_cause_a: assert property (
      (dev_online_out & ~$past(dev_online_out)) != 16'h0000 |-> since_take_ff <= 60)
      else $error("online without message");
   rx_full_a: assert property (
      $fell(rx_ready_out) |-> $past(rx_valid_in && rx_ready_out))
      else $error("ready fell without take");
endmodule

bind rpx_top rpx_top_properties #(.SEC_CYCLES(SEC_CYCLES)) u_rpx_top_properties (.sys_clk_in,
   .arst_n_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out, .pre_op_in, .user_op_in,
   .tx_valid_out, .tx_ready_in, .tx_msg_out, .rx_valid_in, .rx_ready_out, .dev_online_out);

`default_nettype wire

// [dv/rpx_peer.sv]
/*
 * network peer: sinks sent messages with random stalls and
 * sources messages on request. assumes the block's clock.
 */
`default_nettype none

module rpx_peer (
   input wire logic clk_in,
   input wire logic stall_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire rpx_pkg::rpx_msg_s tx_msg_in,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output rpx_pkg::rpx_msg_s rx_msg_out
);
   int got = 0;
   rpx_pkg::rpx_msg_s last_tx;

   initial begin
      tx_ready_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_msg_out = '0;
   end

   // ====================
   // sink, stalls at random
   always @(posedge clk_in) begin
      if (tx_valid_in && tx_ready_out) begin
         got <= got + 1;
         last_tx <= tx_msg_in;
      end
      tx_ready_out <= !stall_in && $urandom_range(1) == 1;
   end

   // ====================
   // source
   // 128 pairs, upper ones empty
   function automatic rpx_pkg::rpx_msg_s mk(input logic [159:0] id, input logic [7:0] hold,
      input logic [63:0] st, input logic [63:0] bad);
      rpx_pkg::rpx_msg_s m;
      m = '0;
      m.origin = id;
      m.hold_s = hold;
      for (int p = 0; p < 64; p++) begin
         m.pairs[2*p+:2] = bad[p] ? {st[p], st[p]} : {st[p], !st[p]};
      end
      return m;
   endfunction

   // held until taken, then line scrambled
   task automatic send(input rpx_pkg::rpx_msg_s m);
      rx_valid_out <= 1'b1;
      rx_msg_out <= m;
      @(posedge clk_in);
      while (!rx_ready_in) @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_msg_out <= ~m;
      // one idle cycle, so a following send never re-drives valid in this step
      @(posedge clk_in);
   endtask
endmodule

`default_nettype wire

// [dv/tb.sv]
/*
 * self-checking bench of the exchange block.
 * assumes rpx_peer as the network side.
 */
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic stall = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] pre = 32'h0;
   logic [31:0] usr = 32'h0;
   logic [31:0] rdat, rin;
   logic [15:0] onl;
   logic txv, txr, rxv, rxr;
   rpx_pkg::rpx_msg_s txm, rxm;
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   int n, k;
   logic [4:0] cdev[32];
   logic [5:0] csel[32];
   logic cdf[32];
   logic [63:0] pts[16];
   logic [15:0] on_m = 16'h0;
   logic [159:0] id1, id3, lid;

   always #10 clk = ~clk;

   rpx_top #(.SEC_CYCLES(SEC)) u_rpx_top (.sys_clk_in(clk), .arst_n_in(rst_n),
      .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdat), .pre_op_in(pre), .user_op_in(usr), .tx_valid_out(txv),
      .tx_ready_in(txr), .tx_msg_out(txm), .rx_valid_in(rxv), .rx_ready_out(rxr),
      .rx_msg_in(rxm), .remote_in_out(rin), .dev_online_out(onl));
   rpx_peer u_rpx_peer (.clk_in(clk), .stall_in(stall), .tx_valid_in(txv), .tx_ready_out(txr),
      .tx_msg_in(txm), .rx_valid_out(rxv), .rx_ready_in(rxr), .rx_msg_out(rxm));

   // ====================
   // helpers
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      check(rdat, e);
   endtask

   function automatic logic [255:0] tx_pairs(input logic [31:0] p, input logic [31:0] u);
      logic [255:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[2*i+:2] = {p[i], !p[i]};
         r[64+2*i+:2] = {u[i], !u[i]};
      end
      return r;
   endfunction

   function automatic logic [31:0] exp_rin();
      logic [31:0] r;
      for (int i = 0; i < 32; i++) begin
         if (cdev[i] inside {[5'h01:5'h10]} && on_m[cdev[i] - 5'h01])
            r[i] = pts[cdev[i] - 5'h01][csel[i]];
         else
            r[i] = cdf[i];
      end
      return r;
   endfunction

   task automatic deliver(input logic [159:0] id, input logic [63:0] st,
      input logic [63:0] bad, input int d);
      u_rpx_peer.send(u_rpx_peer.mk(id, 8'h10, st, bad));
      if (d >= 0) begin
         pts[d] = (pts[d] & bad) | (st & ~bad);
         on_m[d] = 1'b1;
      end
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      check(rin, exp_rin());
      check(onl, on_m);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end

   // ====================
   // scenarios
   initial begin
      void'($urandom(32'hFEDB));
      foreach (pts[i]) pts[i] = 64'h0;
      id1 = {$urandom, $urandom, $urandom, $urandom, $urandom};
      id3 = {$urandom, $urandom, $urandom, $urandom, $urandom};
      lid = {$urandom, $urandom, $urandom, $urandom, $urandom};
      repeat (8) @(posedge clk);
      pre <= $urandom;
      usr <= $urandom;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      while (u_rpx_peer.got == 0) @(posedge clk);
      check(u_rpx_peer.last_tx.hold_s, 8'hB4);
      check(u_rpx_peer.last_tx.pairs, tx_pairs(pre, usr));
      rd_reg(rpx_pkg::ADDR_CTRL, 32'h3C);
      rd_reg(rpx_pkg::ADDR_ONLINE, 32'h0);
      rd_reg(rpx_pkg::ADDR_RIN_VAL, 32'h0);
      wr_reg(8'h03, 32'hFFFFFFFF);
      rd_reg(8'h03, 32'h0);
      wr_reg(rpx_pkg::ADDR_CTRL, 32'h3D);
      wr_reg(rpx_pkg::ADDR_CTRL, 32'h0);
      rd_reg(rpx_pkg::ADDR_CTRL, 32'h3C);
      wr_reg(rpx_pkg::ADDR_CTRL, 32'h1);
      rd_reg(rpx_pkg::ADDR_CTRL, 32'h1);
      for (int w = 0; w < 5; w++) begin
         wr_reg(rpx_pkg::ADDR_LID_BASE + 8'(w), lid[32*w+:32]);
      end
      rd_reg(rpx_pkg::ADDR_LID_BASE + 8'h04, lid[159:128]);
      n = u_rpx_peer.got;
      pre <= $urandom;
      usr <= $urandom;
      // a take at this edge and one message built with old operands may still count
      while (u_rpx_peer.got < n + 3) @(posedge clk);
      check(u_rpx_peer.last_tx.hold_s, 8'h03);
      check(u_rpx_peer.last_tx.origin, lid);
      check(u_rpx_peer.last_tx.pairs, tx_pairs(pre, usr));
      while (!txv) @(posedge clk);
      while (txv) @(posedge clk);
      k = 0;
      while (!txv && k < 100) begin
         k++;
         @(posedge clk);
      end
      check(k <= SEC + 2, 1'b1);
      for (int w = 0; w < 5; w++) begin
         wr_reg(8'h80 + 8'(w), id1[32*w+:32]);
         wr_reg(8'h90 + 8'(w), id3[32*w+:32]);
      end
      for (int i = 0; i < 32; i++) begin
         k = $urandom_range(3);
         cdev[i] = k == 0 ? 5'h01 : k == 1 ? 5'h03 : k == 2 ? 5'h00 : 5'h11;
         csel[i] = i == 0 ? 6'h3F : 6'($urandom_range(63));
         cdf[i] = 1'($urandom_range(1));
         wr_reg(8'h20 + 8'(i), {15'h0, cdf[i], 3'h0, cdev[i], 2'h0, csel[i]});
      end
      settle(1);
      rd_reg(8'h20, {15'h0, cdf[0], 3'h0, cdev[0], 2'h0, csel[0]});
      rd_reg(8'h94, id3[159:128]);
      deliver({~id1[159], id1[158:0]}, {$urandom, $urandom}, 64'h0, -1);
      settle(40);
      deliver(id1, {$urandom, $urandom}, 64'h0, 0);
      settle(40);
      rd_reg(rpx_pkg::ADDR_ONLINE, 32'h1);
      rd_reg(rpx_pkg::ADDR_RIN_VAL, exp_rin());
      deliver(id1, {$urandom, $urandom}, {$urandom, $urandom}, 0);
      settle(40);
      stall <= 1'b1;
      deliver(id3, {$urandom, $urandom}, 64'h0, 2);
      deliver(id1, {$urandom, $urandom}, 64'h0, 0);
      deliver(160'h0, {$urandom, $urandom}, 64'h0, -1);
      stall <= 1'b0;
      settle(60);
      on_m = 16'h0;
      settle(200);
      final_report();
   end
endmodule

`default_nettype wire
